// ---- src/center_clock_select_gate.sv ----
// Purpose: center clock selection: gating, divider, two-input switch, trunk muxes
// Assumes: i_clock is much faster than every routed clock; clocks are sampled levels
// Notes: a pool lane reaches a trunk line through 4 register stages, the switch output through 6, so depths differ
`timescale 1ns/1ps
`default_nettype none
module center_clock_select_gate
  import center_clock_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [NUM_MID-1:0] i_mid_clk,
  input wire logic [NUM_FAB-1:0] i_fabric_clk,
  input wire logic [NUM_POOL-1:0] i_gate_en,
  input wire switch_ctrl_s i_ctrl,
  input wire trunk_sel_t i_trunk_sel,
  output logic [NUM_TRUNK-1:0] o_trunk_clk,
  output logic o_switch_clk,
  output logic o_div_clk,
  output logic o_switch_sel_now
);

  center_state_s st_r;
  center_state_s st_nxt;
  logic [NUM_TRUNK-1:0] trunk_pick;
  logic [NUM_POOL-1:0] raw_clk;
  logic [1:0] sw_in;
  logic div_rise;

  function automatic logic src_pick(input logic [NUM_POOL-1:0] v, input logic [SRC_W-1:0] i);
    return v[i];
  endfunction

  function automatic logic trunk_route(input logic [NUM_POOL-1:0] v, input logic sw,
                                       input logic [SEL_W-1:0] s);
    if (s == SEL_SWITCH) begin
      return sw;
    end else if (s < SEL_SWITCH) begin
      return v[s[SRC_W-1:0]];
    end
    return 1'b0;
  endfunction

  // two trunk muxes, each owning half of the trunk lines
  genvar gm, gt;
  generate
    for (gm = 0; gm < NUM_TMUX; gm++) begin : g_tmux
      for (gt = 0; gt < TRUNK_PER_MUX; gt++) begin : g_line
        assign trunk_pick[gm*TRUNK_PER_MUX+gt] =
          trunk_route(st_r.pool, st_r.sw_out, st_r.sel_s2[gm*TRUNK_PER_MUX+gt]);
      end
    end
  endgenerate

  assign raw_clk = {st_r.fab_s2, st_r.mid_s2};
  assign sw_in = {st_r.alt_clk, st_r.div_out};
  // taken from the source pick directly, so no path loops back through st_nxt
  assign div_rise = src_pick(st_r.pool, st_r.ctrl_s2.div_src) & ~st_r.div_in;

  always_comb begin
    st_nxt = st_r;
    st_nxt.mid_s1 = i_mid_clk;
    st_nxt.mid_s2 = st_r.mid_s1;
    st_nxt.fab_s1 = i_fabric_clk;
    st_nxt.fab_s2 = st_r.fab_s1;
    st_nxt.en_s1 = i_gate_en;
    st_nxt.en_s2 = st_r.en_s1;
    st_nxt.ctrl_s1 = i_ctrl;
    st_nxt.ctrl_s2 = st_r.ctrl_s1;
    st_nxt.sel_s1 = i_trunk_sel;
    st_nxt.sel_s2 = st_r.sel_s1;
    // enable taken only while clock low, so a high phase is never cut short
    for (int k = 0; k < NUM_POOL; k++) begin
      if (!raw_clk[k]) begin
        st_nxt.gate_en[k] = st_r.en_s2[k];
      end
    end
    // one register stage on every lane, gated or not
    st_nxt.pool = raw_clk & st_nxt.gate_en;
    st_nxt.div_in = src_pick(st_r.pool, st_r.ctrl_s2.div_src);
    st_nxt.alt_clk = src_pick(st_r.pool, st_r.ctrl_s2.alt_src);
    if (st_r.ctrl_s2.div_rst) begin
      st_nxt.div_cnt = '0;
      st_nxt.div_out = 1'b0;
    end else begin
      st_nxt.div_cnt = div_rise ? DIV_W'(st_r.div_cnt + DIV_STEP) : st_r.div_cnt;
      if (st_r.ctrl_s2.div_ratio == RATIO_BYPASS) begin
        st_nxt.div_out = st_nxt.div_in;
      end else begin
        st_nxt.div_out = st_nxt.div_cnt[RATIO_W'(st_r.ctrl_s2.div_ratio - RATIO_ONE)];
      end
    end
    st_nxt.sw_out = sw_in[st_r.sw_cur];
    if (st_r.ctrl_s2.sw_plain) begin
      // plain mode may glitch; it needs no running clocks
      st_nxt.sw_state = SW_RUN;
      st_nxt.sw_cur = st_r.ctrl_s2.sw_sel;
      st_nxt.sw_out = sw_in[st_r.ctrl_s2.sw_sel];
    end else begin
      case (st_r.sw_state)
        SW_RUN: begin
          if (st_r.ctrl_s2.sw_sel != st_r.sw_cur) begin
            st_nxt.sw_state = SW_DRAIN_OLD;
          end
        end
        SW_DRAIN_OLD: begin
          // an old clock stopped high stalls here; user keeps both running
          if (!sw_in[st_r.sw_cur]) begin
            st_nxt.sw_state = SW_WAIT_NEW;
            st_nxt.sw_out = 1'b0;
          end
        end
        SW_WAIT_NEW: begin
          st_nxt.sw_out = 1'b0;
          if (!sw_in[~st_r.sw_cur]) begin
            st_nxt.sw_cur = ~st_r.sw_cur;
            st_nxt.sw_state = SW_RUN;
          end
        end
        default: begin
          st_nxt.sw_state = SW_RUN;
          st_nxt.sw_out = 1'b0;
        end
      endcase
    end
    st_nxt.trunk = trunk_pick;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_trunk_clk = st_r.trunk;
  assign o_switch_clk = st_r.sw_out;
  assign o_div_clk = st_r.div_out;
  assign o_switch_sel_now = st_r.sw_cur;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  a_div_reset_low: assert property (st_r.ctrl_s2.div_rst |=> !st_r.div_out)
    else $error("divider output not low under reset");
  a_div_two_toggle: assert property ((!st_r.ctrl_s2.div_rst && st_r.ctrl_s2.div_ratio == RATIO_ONE
    && div_rise) |=> (st_r.div_out != $past(st_r.div_out)))
    else $error("divide by two missed a toggle");
  a_div_first_edge: assert property ((!st_r.ctrl_s2.div_rst && st_r.div_cnt == '0
    && st_r.ctrl_s2.div_ratio == RATIO_ONE && div_rise) |=> st_r.div_out)
    else $error("divider did not start on first input edge");
  a_div_bypass_path: assert property ((!st_r.ctrl_s2.div_rst && st_r.ctrl_s2.div_ratio == RATIO_BYPASS)
    |=> (st_r.div_out == st_r.div_in))
    else $error("bypass does not pass undivided clock");
  a_gate_static_off: assert property ((st_r.pool & ~st_r.gate_en) == '0)
    else $error("disabled lane toggles");
  a_gate_change_low: assert property (((st_r.gate_en ^ $past(st_r.gate_en))
    & $past(raw_clk)) == '0)
    else $error("gate enable changed while clock high");
  a_switch_hold_low: assert property ((st_r.sw_state == SW_WAIT_NEW) |-> !st_r.sw_out)
    else $error("switch output high while waiting for new clock");
  a_switch_follow: assert property ((!st_r.ctrl_s2.sw_plain && st_r.sw_state == SW_RUN
    && st_r.ctrl_s2.sw_sel == st_r.sw_cur) |=> (st_r.sw_out == $past(sw_in[st_r.sw_cur])))
    else $error("switch does not follow selected clock");
  a_trunk_switch_route: assert property ((st_r.sel_s2[0] == SEL_SWITCH)
    |=> (st_r.trunk[0] == $past(st_r.sw_out)))
    else $error("trunk line does not carry switch output");

  // divider counter checks
  a_div_count_hold: assert property ((!st_r.ctrl_s2.div_rst && !div_rise)
    |=> (st_r.div_cnt == $past(st_r.div_cnt)))
    else $error("divider counted without an input edge");
  a_div_rst_count: assert property (st_r.ctrl_s2.div_rst |=> (st_r.div_cnt == '0))
    else $error("divider count not cleared under reset");

  // trunk routing checks
  a_trunk_lane_route: assert property ((st_r.sel_s2[8] < SEL_SWITCH)
    |=> (st_r.trunk[8] == $past(st_r.pool[st_r.sel_s2[8][SRC_W-1:0]])))
    else $error("trunk line does not carry selected lane");
  a_trunk_high_zero: assert property ((st_r.sel_s2[0] > SEL_SWITCH)
    |=> !st_r.trunk[0])
    else $error("unused trunk code drives a clock");

  // switch checks; plain mode trades glitch safety for working with stopped clocks
  a_plain_follow: assert property (st_r.ctrl_s2.sw_plain
    |=> (st_r.sw_out == $past(sw_in[st_r.ctrl_s2.sw_sel])))
    else $error("plain switch does not follow select");
  a_drain_hold_sel: assert property ((!st_r.ctrl_s2.sw_plain && st_r.sw_state == SW_DRAIN_OLD)
    |=> (st_r.sw_cur == $past(st_r.sw_cur)))
    else $error("switch left old clock before draining");
  a_drain_old_high: assert property ((!st_r.ctrl_s2.sw_plain && st_r.sw_state == SW_DRAIN_OLD
    && sw_in[st_r.sw_cur]) |=> st_r.sw_out)
    else $error("old clock high phase cut short");
  a_new_flip: assert property ((!st_r.ctrl_s2.sw_plain && st_r.sw_state == SW_WAIT_NEW
    && !sw_in[~st_r.sw_cur]) |=> (st_r.sw_cur != $past(st_r.sw_cur)))
    else $error("switch did not take new clock when low");

endmodule // center_clock_select_gate
`default_nettype wire

// ---- src/center_clock_pkg.sv ----
// Purpose: shared constants and carriers for the center clock select and gate block
// Assumes: all clocks are sampled as levels by one fast system clock
// Notes: lane 0..59 are mid-level mux sources, lanes 60..63 fabric clocks
package center_clock_pkg;
  localparam int NUM_MID = 60;
  localparam int NUM_FAB = 4;
  localparam int NUM_POOL = 64;
  localparam int NUM_TRUNK = 16;
  localparam int NUM_TMUX = 2;
  localparam int TRUNK_PER_MUX = 8;
  localparam int SEL_W = 7;
  localparam int SRC_W = 6;
  localparam int DIV_W = 7;
  localparam int RATIO_W = 3;
  localparam logic [SEL_W-1:0] SEL_SWITCH = 7'h40;
  localparam logic [RATIO_W-1:0] RATIO_BYPASS = 3'h0;
  localparam logic [RATIO_W-1:0] RATIO_ONE = 3'h1;
  localparam logic [DIV_W-1:0] DIV_STEP = 7'h01;

  typedef enum logic [1:0] {SW_RUN, SW_DRAIN_OLD, SW_WAIT_NEW} switch_state_e;

  // controls from fabric logic
  typedef struct packed {
    logic sw_sel;                 // 0: divider path, 1: alternate path
    logic sw_plain;               // 1: plain multiplexer, 0: glitch-free
    logic div_rst;                // divider reset, active high
    logic [RATIO_W-1:0] div_ratio; // 0 bypass, n divides by 2**n
    logic [SRC_W-1:0] div_src;    // divider source mux select
    logic [SRC_W-1:0] alt_src;    // second source mux select
  } switch_ctrl_s;

  typedef logic [NUM_TRUNK-1:0][SEL_W-1:0] trunk_sel_t;

  typedef struct packed {
    logic [NUM_MID-1:0] mid_s1;
    logic [NUM_MID-1:0] mid_s2;
    logic [NUM_FAB-1:0] fab_s1;
    logic [NUM_FAB-1:0] fab_s2;
    logic [NUM_POOL-1:0] en_s1;
    logic [NUM_POOL-1:0] en_s2;
    switch_ctrl_s ctrl_s1;
    switch_ctrl_s ctrl_s2;
    trunk_sel_t sel_s1;
    trunk_sel_t sel_s2;
    logic [NUM_POOL-1:0] gate_en;
    logic [NUM_POOL-1:0] pool;
    logic [DIV_W-1:0] div_cnt;
    logic div_in;
    logic div_out;
    logic alt_clk;
    switch_state_e sw_state;
    logic sw_cur;
    logic sw_out;
    logic [NUM_TRUNK-1:0] trunk;
  } center_state_s;
endpackage

// ---- sim/fabric_clock_src.sv ----
// Purpose: stand-in for the mid-level and fabric clock sources
// Assumes: every source is slow against i_clock, one power-of-two rate each
// Notes: sources never stop, so a glitch-free switch can always finish
`timescale 1ns/1ps
`default_nettype none
module fabric_clock_src (
  input wire logic i_clock,
  output logic [59:0] o_mid_clk,
  output logic [3:0] o_fabric_clk
);
  logic [8:0] cnt_r = 9'h000;
  // free running on purpose: a stalled source would hang the switch
  always @(posedge i_clock) cnt_r <= #1 cnt_r + 9'h001;
  assign o_mid_clk = {60{cnt_r[1]}};
  assign o_fabric_clk = cnt_r[5:2];
endmodule // fabric_clock_src
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the center clock select and gate block
// Assumes: mid lanes run at period 4, fabric lane j at period 2**(j+3)
// Notes: rates are judged by edge counts, so one edge of slack is allowed
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, a, e); end end
module testbench;
  import center_clock_pkg::*;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic [NUM_MID-1:0] mid;
  logic [NUM_FAB-1:0] fab;
  logic [NUM_POOL-1:0] gate_en = '1;
  switch_ctrl_s ctrl = '0;
  trunk_sel_t tsel = '0;
  logic [NUM_TRUNK-1:0] trunk;
  logic sw_clk, div_clk, sel_now;
  logic [3:0] prev = 4'h0;
  int n_mismatch = 0;
  int n_checks = 0;
  int c_t0, c_t8, c_div, c_sw, run, minp;
  always #50 i_clock = ~i_clock;
  fabric_clock_src src (.i_clock(i_clock), .o_mid_clk(mid), .o_fabric_clk(fab));
  center_clock_select_gate uut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_mid_clk(mid),
    .i_fabric_clk(fab), .i_gate_en(gate_en), .i_ctrl(ctrl), .i_trunk_sel(tsel),
    .o_trunk_clk(trunk), .o_switch_clk(sw_clk), .o_div_clk(div_clk),
    .o_switch_sel_now(sel_now));
  // rising edges per output, and the shortest switch pulse seen
  always @(posedge i_clock) begin
    if (trunk[0] && !prev[0]) c_t0++;
    if (trunk[8] && !prev[1]) c_t8++;
    if (div_clk && !prev[2]) c_div++;
    if (sw_clk && !prev[3]) c_sw++;
    if (sw_clk !== prev[3]) begin
      if (run < minp) minp = run;
      run = 1;
    end else
      run++;
    prev = {sw_clk, div_clk, trunk[8], trunk[0]};
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // a partial first pulse must not count, hence run starts high
  task automatic clr;
    c_t0 = 0;
    c_t8 = 0;
    c_div = 0;
    c_sw = 0;
    minp = 99;
    run = 99;
  endtask
  task automatic near(input int a, input int e);
    `CHK((a + 1 >= e) && (a <= e + 1), 1'b1)
  endtask
  task automatic t_gate;
    tsel[0] = 7'h3C;
    gate_en[60] = 1'b0;
    step(16);
    clr;
    step(64);
    `CHK(c_t0, 0)
    near(c_t8, 16);
    gate_en[0] = 1'b0;
    step(16);
    clr;
    step(64);
    `CHK(c_t8, 0)
    gate_en[0] = 1'b1;
    gate_en[60] = 1'b1;
    tsel[8] = 7'h41;
    step(16);
    clr;
    step(64);
    near(c_t0, 8);
    `CHK(c_t8, 0)
  endtask
  task automatic t_div;
    for (int n = 0; n < 8; n++) begin
      ctrl.div_ratio = 3'(n);
      step(24);
      clr;
      step(1024);
      near(c_div, 256 >> n);
    end
    ctrl.div_rst = 1'b1;
    step(8);
    clr;
    step(64);
    `CHK(c_div, 0)
    ctrl.div_rst = 1'b0;
    ctrl.div_ratio = RATIO_ONE;
    clr;
    step(16);
    `CHK(c_div > 0, 1'b1)
  endtask
  task automatic t_switch;
    tsel[0] = SEL_SWITCH;
    ctrl = '0;
    ctrl.div_src = 6'h3C;
    ctrl.alt_src = 6'h3F;
    ctrl.sw_sel = 1'b1;
    step(300);
    `CHK(sel_now, 1'b1)
    clr;
    for (int k = 0; k < 6; k++) begin
      ctrl.sw_sel = ~ctrl.sw_sel;
      step(37 + k * 11);
    end
    `CHK(minp >= 3, 1'b1)
    ctrl.sw_sel = 1'b0;
    step(300);
    clr;
    step(256);
    near(c_sw, 32);
    near(c_t0, 32);
    ctrl.sw_plain = 1'b1;
    ctrl.sw_sel = 1'b1;
    step(8);
    `CHK(sel_now, 1'b1)
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    step(8);
    i_arst_n = 1'b1;
    t_gate;
    t_div;
    t_switch;
    give_verdict;
  end
  initial begin
    #3000000;
    n_mismatch++;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
